//--- core/fcsa_pkg.sv
// Purpose: shared constants for the flow counter, simulator and alarm block
// Assumes: 40 MHz ref_clk, 32-bit register port with word indices
// Notes:   volume accumulators count in flow-units x time-base ticks
package fcsa_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int TICK_MS       = 20;                     // measurement time base
  localparam int TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
  localparam int MIN_MS        = 60_000;
  localparam int TICKS_PER_MIN = MIN_MS / TICK_MS;
  localparam logic [4:0] TMO_MIN_LO = 5'h01;             // minutes
  localparam logic [4:0] TMO_MIN_HI = 5'h1E;             // minutes
  localparam logic [4:0] TMO_RST    = 5'h0A;             // minutes
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CUTOFF   = 8'h01;
  localparam logic [7:0] REG_USERUNIT = 8'h02;
  localparam logic [7:0] REG_SIMSTART = 8'h03;
  localparam logic [7:0] REG_SIMINC   = 8'h04;
  localparam logic [7:0] REG_SIMIVL   = 8'h05;
  localparam logic [7:0] REG_SIMNIVL  = 8'h06;
  localparam logic [7:0] REG_SIMTMO   = 8'h07;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_FLOW     = 8'h09;
  localparam logic [7:0] REG_TOTAL    = 8'h0A;
  localparam logic [7:0] REG_PART     = 8'h0B;
  localparam logic [7:0] REG_ALM_BASE = 8'h0C;           // per channel: cfg, thr, lo, hyst
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTL_TOT_BIDIR  = 0;
  localparam int CTL_PART_BIDIR = 1;
  localparam int CTL_PART_CLR   = 2;                     // write-one pulse, reads 0
  localparam int CTL_MENU       = 3;
  localparam int CTL_SIM_EN     = 4;
  localparam int CTL_SIM_MODE   = 5;                     // 2 bits
  localparam int CTL_SIM_PART   = 7;
  localparam int CTL_TOT_UNIT   = 8;                     // 3 bits
  localparam int CTL_PART_UNIT  = 11;                    // 3 bits
  localparam logic [13:0] CTRL_RST = 14'h0000;
  // alarm cfg fields: [1:0] source, [2] alarm type, [3] window, [4] normally closed
  localparam int ACF_SRC = 0;
  localparam int ACF_ALM = 2;
  localparam int ACF_WIN = 3;
  localparam int ACF_NC  = 4;
  // ----------------------------------------------------------------
  // volume unit sizes in millilitres
  // ----------------------------------------------------------------
  localparam logic [31:0] UNIT_ML  = 32'h0000_0001;
  localparam logic [31:0] UNIT_L   = 32'h0000_03E8;
  localparam logic [31:0] UNIT_M3  = 32'h000F_4240;
  localparam logic [31:0] UNIT_GUS = 32'h0000_0EC9;
  localparam logic [31:0] UNIT_GUK = 32'h0000_11C2;
  localparam logic [31:0] USER_RST = 32'h0000_03E8;
  typedef enum logic [1:0] {FCSA_SIM_TRI = 2'h0, FCSA_SIM_MONO = 2'h1,
                            FCSA_SIM_STAT = 2'h2} fcsa_sim_mode_t;
  typedef enum logic [2:0] {FCSA_IDLE = 3'h0, FCSA_UP = 3'h1, FCSA_DOWN = 3'h3,
                            FCSA_HOLD = 3'h2, FCSA_DONE = 3'h6} fcsa_sim_state_t;
endpackage

//--- core/fcsa_top.sv
// Purpose: volume totalisers, measured-value simulator, two alarm outputs
// Assumes: flow_meas comes from logic on ref_clk, signed, in ml per minute
// Notes:   all state lives in one packed struct, updated by one always_ff
//
// Functional notes
// - Absolute mode adds every partial volume regardless of flow sign.
// - Bidirectional mode adds or subtracts by sign; counter may go negative.
// - Unit change converts the shown counter value, never clears it.
// - Part counter reset sets part to zero, total untouched.
// - Simulation stops at timeout (1..30 min) or, in monotonic mode, when intervals complete.
// - Simulation starts when enabled and menu left; menu entry interrupts it.
// - Running flow simulation replaces measured value for display and all outputs.
// - Triangle: up by increment per interval, N intervals, then down, repeat.
// - Monotonic: up by increment per interval, stop after N or timeout.
// - Static flow simulation holds a constant value until timeout.
// - Static part-counter simulation changes counter once by increment at start.
// - Limit: assert above threshold, release below threshold minus hysteresis.
// - Window: assert when flow lies outside lower..upper band.
// - Window: release only inside band shrunk by hysteresis at both edges.
// - NO sense activates above threshold; NC sense active below, off above.
// - Window with NC sense asserts inside the window.
// - Lower threshold ignored in limit function.
// - Thresholds are signed and compared signed.
// - Two independent outputs, each with own source and output type.
// - Low-flow cutoff limited to zero..range start, default range start.
// - Flow below cutoff is forced to zero.
// - Measured values processed on a 20 ms time base.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module fcsa_top #(
  parameter int          TICK_CYC    = fcsa_pkg::TICK_CYC,  // cycles per time base
  parameter logic [31:0] RANGE_START = 32'h0000_0064        // measuring range start
) (
  input  wire logic        ref_clk,    // 40 MHz
  input  wire logic        arst_n,     // async reset, active low
  input  wire logic [31:0] flow_meas,  // signed measured flow
  input  wire logic [7:0]  reg_addr,   // register index
  input  wire logic [31:0] reg_wdata,  // write data
  input  wire logic        reg_wr,     // write strobe
  input  wire logic        reg_rd,     // read strobe
  output logic      [31:0] reg_rdata,  // read data, cycle after reg_rd
  output logic      [1:0]  sw_out,     // switching outputs, high = active
  output logic      [31:0] flow_out,   // flow value fed to display and outputs
  output logic             sim_active  // simulation running
);
  localparam int TPM = fcsa_pkg::TICKS_PER_MIN;

  typedef struct packed {
    logic [13:0]        ctrl;
    logic [31:0]        cutoff;
    logic [31:0]        user_unit;
    logic [31:0]        sim_start;
    logic [31:0]        sim_inc;
    logic [31:0]        sim_ivl;
    logic [31:0]        sim_nivl;
    logic [4:0]         sim_tmo;
    logic [1:0][4:0]    a_cfg;
    logic [1:0][31:0]   a_thr;
    logic [1:0][31:0]   a_lo;
    logic [1:0][31:0]   a_hyst;
    logic [31:0]        tick_cnt;
    logic               tick;
    logic signed [31:0] flow_eff;
    logic signed [63:0] tot_acc;
    logic signed [63:0] part_acc;
    fcsa_pkg::fcsa_sim_state_t st;
    logic signed [31:0] sim_val;
    logic [31:0]        ivl_cnt;
    logic [31:0]        step_cnt;
    logic [16:0]        tmo_cnt;
    logic [1:0]         outside;
    logic [1:0]         sw;
    logic [31:0]        rdata;
  } fcsa_state_t;

  fcsa_state_t s;
  fcsa_state_t next_s;

  // ------------------------------------------------------------------
  // unit conversion helpers
  // ------------------------------------------------------------------
  // divisor turning accumulator units into the selected volume unit
  function automatic logic signed [63:0] fcsa_div(input logic [2:0] u,
                                                  input logic [31:0] user);
    logic [31:0] ml;
    ml = fcsa_pkg::UNIT_ML;
    case (u)
      3'h1:    ml = fcsa_pkg::UNIT_L;
      3'h2:    ml = fcsa_pkg::UNIT_M3;
      3'h3:    ml = fcsa_pkg::UNIT_GUS;
      3'h4:    ml = fcsa_pkg::UNIT_GUK;
      3'h5:    ml = (user == 32'h0000_0000) ? fcsa_pkg::UNIT_ML : user;
      default: ml = fcsa_pkg::UNIT_ML;
    endcase
    return $signed({32'h0000_0000, ml}) * 64'(TPM);
  endfunction

  // readouts always derive from the base accumulator, so a unit change
  // converts the shown value instead of losing it
  logic signed [63:0] tot_conv;
  logic signed [63:0] part_conv;
  assign tot_conv  = s.tot_acc / fcsa_div(s.ctrl[fcsa_pkg::CTL_TOT_UNIT +: 3],
                                          s.user_unit);
  assign part_conv = s.part_acc / fcsa_div(s.ctrl[fcsa_pkg::CTL_PART_UNIT +: 3],
                                           s.user_unit);

  // ------------------------------------------------------------------
  // alarm comparators, one per channel
  // ------------------------------------------------------------------
  logic [1:0] next_outside;
  logic [1:0] next_sw;
  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++)
    begin : g_alm
      logic signed [31:0] v;
      logic signed [31:0] thr;
      logic signed [31:0] lo;
      logic signed [31:0] hy;
      logic               o;
      // each channel picks its own source
      always_comb
      begin
        case (s.a_cfg[gc][fcsa_pkg::ACF_SRC +: 2])
          2'h1:    v = tot_conv[31:0];
          2'h2:    v = part_conv[31:0];
          default: v = s.flow_eff;
        endcase
      end
      assign thr = $signed(s.a_thr[gc]);
      assign lo  = $signed(s.a_lo[gc]);
      assign hy  = $signed(s.a_hyst[gc]);
      // previous state selects set or release threshold
      always_comb
      begin
        if (s.a_cfg[gc][fcsa_pkg::ACF_WIN])
        begin
          if (!s.outside[gc])
            o = (v > thr) || (v < lo);
          else
            o = !((v < thr - hy) && (v > lo + hy));
        end
        else if (!s.outside[gc])
          o = v > thr;
        else
          o = !(v < thr - hy);
      end
      assign next_outside[gc] = o;
      // NC inverts the sense; non-alarm types leave the pin inactive
      assign next_sw[gc] = s.a_cfg[gc][fcsa_pkg::ACF_ALM] &
                           (o ^ s.a_cfg[gc][fcsa_pkg::ACF_NC]);
    end
  endgenerate

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    logic signed [31:0] fm;
    logic signed [31:0] mag;
    logic signed [31:0] pv;
    logic               run;
    logic               sim_flow;
    logic               sim_part;
    logic [16:0]        tmo_lim;
    logic [1:0]         mode;
    logic signed [63:0] inc_acc;
    fm       = $signed(flow_meas);
    mag      = 32'h0000_0000;
    pv       = 32'h0000_0000;
    next_s   = s;
    run      = (s.st == fcsa_pkg::FCSA_UP) || (s.st == fcsa_pkg::FCSA_DOWN) ||
               (s.st == fcsa_pkg::FCSA_HOLD);
    sim_flow = run && !s.ctrl[fcsa_pkg::CTL_SIM_PART];
    sim_part = run && s.ctrl[fcsa_pkg::CTL_SIM_PART];
    tmo_lim  = 17'(s.sim_tmo) * 17'(TPM);
    mode     = s.ctrl[fcsa_pkg::CTL_SIM_MODE +: 2];
    inc_acc  = 64'($signed(s.sim_inc)) * 64'(TPM);
    next_s.rdata = 32'h0000_0000;
    next_s.ctrl[fcsa_pkg::CTL_PART_CLR] = 1'b0;

    // time base divider
    next_s.tick = 1'b0;
    if (s.tick_cnt >= 32'(TICK_CYC - 1))
    begin
      next_s.tick_cnt = 32'h0000_0000;
      next_s.tick     = 1'b1;
    end
    else
      next_s.tick_cnt = s.tick_cnt + 32'h0000_0001;

    // cutoff then simulation override
    mag = (fm < 0) ? -fm : fm;
    if (sim_flow)
      next_s.flow_eff = s.sim_val;
    else if (mag < $signed(s.cutoff))
      next_s.flow_eff = 32'h0000_0000;
    else
      next_s.flow_eff = fm;

    // totalisers, once per time base
    pv = s.flow_eff;
    if (s.tick)
    begin
      if (s.ctrl[fcsa_pkg::CTL_TOT_BIDIR])
        next_s.tot_acc = s.tot_acc + 64'(pv);
      else
        next_s.tot_acc = s.tot_acc + 64'((pv < 0) ? -pv : pv);
      if (!sim_part)
      begin
        if (s.ctrl[fcsa_pkg::CTL_PART_BIDIR])
          next_s.part_acc = s.part_acc + 64'(pv);
        else
          next_s.part_acc = s.part_acc + 64'((pv < 0) ? -pv : pv);
      end
    end

    // simulator sequencing
    if (s.ctrl[fcsa_pkg::CTL_MENU] || !s.ctrl[fcsa_pkg::CTL_SIM_EN])
      next_s.st = fcsa_pkg::FCSA_IDLE;
    else
    begin
      case (s.st)
        fcsa_pkg::FCSA_IDLE:
        begin
          next_s.sim_val  = $signed(s.sim_start);
          next_s.ivl_cnt  = 32'h0000_0000;
          next_s.step_cnt = 32'h0000_0000;
          next_s.tmo_cnt  = 17'h00000;
          if (mode == fcsa_pkg::FCSA_SIM_STAT)
          begin
            next_s.st = fcsa_pkg::FCSA_HOLD;
            // build on next_s so a same-cycle tick accumulation is kept
            if (s.ctrl[fcsa_pkg::CTL_SIM_PART])
              next_s.part_acc = next_s.part_acc + inc_acc;
          end
          else
            next_s.st = fcsa_pkg::FCSA_UP;
        end
        fcsa_pkg::FCSA_UP, fcsa_pkg::FCSA_DOWN, fcsa_pkg::FCSA_HOLD:
        begin
          if (s.tick)
          begin
            next_s.tmo_cnt = s.tmo_cnt + 17'h00001;
            if (s.tmo_cnt + 17'h00001 >= tmo_lim)
              next_s.st = fcsa_pkg::FCSA_DONE;
            else if (s.st != fcsa_pkg::FCSA_HOLD)
            begin
              next_s.ivl_cnt = s.ivl_cnt + 32'h0000_0001;
              if (s.ivl_cnt + 32'h0000_0001 >= s.sim_ivl)
              begin
                next_s.ivl_cnt  = 32'h0000_0000;
                next_s.step_cnt = s.step_cnt + 32'h0000_0001;
                if (s.st == fcsa_pkg::FCSA_UP)
                begin
                  next_s.sim_val = s.sim_val + $signed(s.sim_inc);
                  if (sim_part)
                    next_s.part_acc = s.part_acc + inc_acc;
                end
                else
                begin
                  next_s.sim_val = s.sim_val - $signed(s.sim_inc);
                  if (sim_part)
                    next_s.part_acc = s.part_acc - inc_acc;
                end
                if (s.step_cnt + 32'h0000_0001 >= s.sim_nivl)
                begin
                  next_s.step_cnt = 32'h0000_0000;
                  if (mode == fcsa_pkg::FCSA_SIM_MONO)
                    next_s.st = fcsa_pkg::FCSA_DONE;
                  else if (s.st == fcsa_pkg::FCSA_UP)
                    next_s.st = fcsa_pkg::FCSA_DOWN;
                  else
                    next_s.st = fcsa_pkg::FCSA_UP;
                end
              end
            end
          end
        end
        fcsa_pkg::FCSA_DONE: next_s.st = fcsa_pkg::FCSA_DONE;
        default:             next_s.st = fcsa_pkg::FCSA_IDLE;
      endcase
    end

    // alarm evaluation once per time base
    if (s.tick)
    begin
      next_s.outside = next_outside;
      next_s.sw      = next_sw;
    end

    // register writes; a reset request wins over a same-cycle accumulation
    if (reg_wr)
    begin
      case (reg_addr)
        fcsa_pkg::REG_CTRL:
        begin
          next_s.ctrl = reg_wdata[13:0];
          next_s.ctrl[fcsa_pkg::CTL_PART_CLR] = 1'b0;
          if (reg_wdata[fcsa_pkg::CTL_PART_CLR])
            next_s.part_acc = 64'h0;
        end
        fcsa_pkg::REG_CUTOFF:
          if ($signed(reg_wdata) < 0)
            next_s.cutoff = 32'h0000_0000;
          else if (reg_wdata > RANGE_START)
            next_s.cutoff = RANGE_START;
          else
            next_s.cutoff = reg_wdata;
        fcsa_pkg::REG_USERUNIT: next_s.user_unit = reg_wdata;
        fcsa_pkg::REG_SIMSTART: next_s.sim_start = reg_wdata;
        fcsa_pkg::REG_SIMINC:   next_s.sim_inc   = reg_wdata;
        fcsa_pkg::REG_SIMIVL:   next_s.sim_ivl   = reg_wdata;
        fcsa_pkg::REG_SIMNIVL:  next_s.sim_nivl  = reg_wdata;
        fcsa_pkg::REG_SIMTMO:
          if (reg_wdata[31:0] < 32'(fcsa_pkg::TMO_MIN_LO))
            next_s.sim_tmo = fcsa_pkg::TMO_MIN_LO;
          else if (reg_wdata[31:0] > 32'(fcsa_pkg::TMO_MIN_HI))
            next_s.sim_tmo = fcsa_pkg::TMO_MIN_HI;
          else
            next_s.sim_tmo = reg_wdata[4:0];
        default:
          for (int c = 0; c < 2; c++)
          begin
            if (reg_addr == fcsa_pkg::REG_ALM_BASE + 8'(4 * c))
              next_s.a_cfg[c] = reg_wdata[4:0];
            if (reg_addr == fcsa_pkg::REG_ALM_BASE + 8'(4 * c + 1))
              next_s.a_thr[c] = reg_wdata;
            if (reg_addr == fcsa_pkg::REG_ALM_BASE + 8'(4 * c + 2))
              next_s.a_lo[c] = reg_wdata;
            if (reg_addr == fcsa_pkg::REG_ALM_BASE + 8'(4 * c + 3))
              next_s.a_hyst[c] = reg_wdata;
          end
      endcase
    end

    // register reads, unmapped indices answer zero
    if (reg_rd)
    begin
      case (reg_addr)
        fcsa_pkg::REG_CTRL:     next_s.rdata = {18'h00000, s.ctrl};
        fcsa_pkg::REG_CUTOFF:   next_s.rdata = s.cutoff;
        fcsa_pkg::REG_USERUNIT: next_s.rdata = s.user_unit;
        fcsa_pkg::REG_SIMSTART: next_s.rdata = s.sim_start;
        fcsa_pkg::REG_SIMINC:   next_s.rdata = s.sim_inc;
        fcsa_pkg::REG_SIMIVL:   next_s.rdata = s.sim_ivl;
        fcsa_pkg::REG_SIMNIVL:  next_s.rdata = s.sim_nivl;
        fcsa_pkg::REG_SIMTMO:   next_s.rdata = {27'h0000000, s.sim_tmo};
        fcsa_pkg::REG_STATUS:   next_s.rdata = {25'h0000000, s.sw, s.outside, s.st};
        fcsa_pkg::REG_FLOW:     next_s.rdata = s.flow_eff;
        fcsa_pkg::REG_TOTAL:    next_s.rdata = tot_conv[31:0];
        fcsa_pkg::REG_PART:     next_s.rdata = part_conv[31:0];
        default:
          for (int c = 0; c < 2; c++)
          begin
            if (reg_addr == fcsa_pkg::REG_ALM_BASE + 8'(4 * c))
              next_s.rdata = {27'h0000000, s.a_cfg[c]};
            if (reg_addr == fcsa_pkg::REG_ALM_BASE + 8'(4 * c + 1))
              next_s.rdata = s.a_thr[c];
            if (reg_addr == fcsa_pkg::REG_ALM_BASE + 8'(4 * c + 2))
              next_s.rdata = s.a_lo[c];
            if (reg_addr == fcsa_pkg::REG_ALM_BASE + 8'(4 * c + 3))
              next_s.rdata = s.a_hyst[c];
          end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s           <= '0;
      s.ctrl      <= fcsa_pkg::CTRL_RST;
      s.cutoff    <= RANGE_START;
      s.user_unit <= fcsa_pkg::USER_RST;
      s.sim_tmo   <= fcsa_pkg::TMO_RST;
      s.st        <= fcsa_pkg::FCSA_IDLE;
    end
    else
      s <= next_s;
  end

  assign reg_rdata  = s.rdata;
  assign sw_out     = s.sw;
  assign flow_out   = s.flow_eff;
  assign sim_active = (s.st == fcsa_pkg::FCSA_UP) || (s.st == fcsa_pkg::FCSA_DOWN) ||
                      (s.st == fcsa_pkg::FCSA_HOLD);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_part_clr;
    reg_wr && reg_addr == fcsa_pkg::REG_CTRL && reg_wdata[fcsa_pkg::CTL_PART_CLR]
      |=> s.part_acc == 64'h0;
  endproperty
  a_part_clr: assert property (p_part_clr) else $error("part reset missed");

  property p_abs_total;
    s.tick && !s.ctrl[fcsa_pkg::CTL_TOT_BIDIR] |=> s.tot_acc >= $past(s.tot_acc);
  endproperty
  a_abs_total: assert property (p_abs_total) else $error("absolute total fell");

  property p_bidir_total;
    s.tick && s.ctrl[fcsa_pkg::CTL_TOT_BIDIR]
      |=> s.tot_acc == $past(s.tot_acc) + 64'($past(s.flow_eff));
  endproperty
  a_bidir_total: assert property (p_bidir_total) else $error("signed add wrong");

  property p_menu_stop;
    s.ctrl[fcsa_pkg::CTL_MENU] |=> !sim_active;
  endproperty
  a_menu_stop: assert property (p_menu_stop) else $error("sim ran in menu");

  property p_sim_flow;
    sim_active && !s.ctrl[fcsa_pkg::CTL_SIM_PART] |=> s.flow_eff == $past(s.sim_val);
  endproperty
  a_sim_flow: assert property (p_sim_flow) else $error("sim value not fed");

  property p_cutoff_zero;
    !sim_active && $signed(flow_meas) < $signed(s.cutoff)
      && -$signed(flow_meas) < $signed(s.cutoff) |=> s.flow_eff == 32'h0000_0000;
  endproperty
  a_cutoff_zero: assert property (p_cutoff_zero) else $error("cutoff not applied");

  property p_cutoff_rng;
    !s.cutoff[31] && s.cutoff <= RANGE_START;
  endproperty
  a_cutoff_rng: assert property (p_cutoff_rng) else $error("cutoff out of range");

  property p_tmo;
    sim_active |-> s.tmo_cnt < 17'(s.sim_tmo) * 17'(TPM);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout overrun");

  property p_limit_set;
    s.tick && s.a_cfg[0] == 5'h04 && s.flow_eff > $signed(s.a_thr[0]) |=> sw_out[0];
  endproperty
  a_limit_set: assert property (p_limit_set) else $error("limit not asserted");

  property p_win_nc;
    s.tick && s.a_cfg[1] == 5'h1C && !s.outside[1]
      && s.flow_eff < $signed(s.a_thr[1]) && s.flow_eff > $signed(s.a_lo[1])
      |=> sw_out[1];
  endproperty
  a_win_nc: assert property (p_win_nc) else $error("NC window wrong");

  c_tri_down: cover property (s.st == fcsa_pkg::FCSA_DOWN);
  c_done:     cover property (s.st == fcsa_pkg::FCSA_DONE);
  c_alarm:    cover property (sw_out[0] ##1 !sw_out[0]);
endmodule

//--- dv/fcsa_ctl_model.sv
// Purpose: external controller that reads the switching outputs
// Assumes: output levels are sampled on ref_clk
// Notes:   a controller only listens, it never drives the block
`timescale 1ns/1ps
module fcsa_ctl_model (
  input  wire logic       ref_clk, // block clock
  input  wire logic [1:0] sw_in,   // switching output levels
  output logic      [1:0] seen     // last sampled levels
);
  // sample once a clock, like a polling controller input
  always_ff @(posedge ref_clk)
  begin
    seen <= sw_in;
  end
endmodule

//--- dv/fcsa_top_bench.sv
// Purpose: self-checking bench for the counter, simulator and alarm block
// Assumes: TICK_CYC cut to 16 so a time base tick is 16 clocks
// Notes:   alarm states come from an integer model of the hysteresis
`timescale 1ns/1ps
module fcsa_top_bench;
  logic        ref_clk, arst_n, reg_wr, reg_rd, sim_active;
  logic [7:0]  reg_addr;
  logic [31:0] flow_meas, reg_wdata, reg_rdata, flow_out, rd;
  logic [1:0]  sw_out, seen;
  int          num_errors, n_checks, st0, st1, mx, k, f, t;
  int          tbl [8] = '{1100, 950, 850, 1050, 350, 250, 450, 600};
  fcsa_top #(.TICK_CYC(16)) fcsa_top_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .flow_meas(flow_meas), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_out(sw_out), .flow_out(flow_out),
    .sim_active(sim_active));
  fcsa_ctl_model fcsa_ctl_model_inst (.ref_clk(ref_clk), .sw_in(sw_out), .seen(seen));
  // 40 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // one-cycle strobes; read data taken in the cycle after the strobe
  // a write lets one edge pass after lowering its strobe, so the next
  // call never raises it again in the same time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    w(1);
    reg_wr <= 1'b0;
    w(1);
  endtask
  task automatic rdr(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    w(1);
    reg_rd <= 1'b0;
    w(1);
    rd = reg_rdata;
  endtask
  // next alarm state; strict compares keep the old state inside the hysteresis
  function automatic int alm(int s, int fl, int th, int lo, int hy, bit win);
    if (win)
      return (fl > th || fl < lo) ? 1 : ((fl < th - hy && fl > lo + hy) ? 0 : s);
    return (fl > th) ? 1 : ((fl < th - hy) ? 0 : s);
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, flow_meas} = '0;
    {num_errors, n_checks, st0, st1} = '0;
    k = $urandom(32'hA8CB);
    w(2);
    arst_n <= 1'b1;
    w(1);
    rdr(8'h01);
    chk("cutoff", 32'h64, rd);
    wr(8'h01, 32'h28);
    rdr(8'h01);
    chk("cutoff_wr", 32'h28, rd);
    wr(8'h01, 32'hC8);
    rdr(8'h01);
    chk("clamp", 32'h64, rd);
    flow_meas <= 32'h96;
    w(3);
    chk("pass", 32'h96, flow_out);
    flow_meas <= 32'hFFFF_FFCE;
    w(3);
    chk("cut", 32'h0, flow_out);
    // ch0 limit, normally open, lower threshold set high to show it is ignored
    wr(8'h0C, 32'h04);
    wr(8'h0D, 32'h3E8);
    wr(8'h0E, 32'h7D0);
    wr(8'h0F, 32'h64);
    // ch1 window, normally closed
    wr(8'h10, 32'h1C);
    wr(8'h11, 32'h3E8);
    wr(8'h12, 32'h12C);
    wr(8'h13, 32'h64);
    for (int i = 0; i < 9; i++)
    begin
      f = (i == 8) ? 100 + $urandom % 1900 : tbl[i];
      flow_meas <= f;
      w(40);
      st0 = alm(st0, f, 1000, 2000, 100, 0);
      st1 = alm(st1, f, 1000, 300, 100, 1);
      chk("flow", f, flow_out);
      chk("sw0", st0, sw_out[0]);
      chk("sw1", !st1, sw_out[1]);
      chk("seen", {!st1, st0[0]}, seen);
    end
    flow_meas <= 32'h0;
    w(40);
    rdr(8'h0A);
    t = rd;
    wr(8'h02, 32'h2);
    wr(8'h00, 32'h500);
    rdr(8'h0A);
    chk("unit", t / 2, rd);
    wr(8'h00, 32'h504);
    rdr(8'h0B);
    chk("part", 32'h0, rd);
    rdr(8'h0A);
    chk("total", t / 2, rd);
    // monotonic run: 2000 up by 100, three intervals of two ticks
    wr(8'h03, 32'h7D0);
    wr(8'h04, 32'h64);
    wr(8'h05, 32'h2);
    wr(8'h06, 32'h3);
    wr(8'h00, 32'h18);
    wr(8'h00, 32'h30);
    mx = 0;
    for (k = 0; k < 3000 && !(k > 3 && sim_active !== 1'b1); k++)
    begin
      w(1);
      if (sim_active === 1'b1 && flow_out > mx)
        mx = flow_out;
    end
    if (k == 3000)
    begin
      num_errors++;
      test_done();
    end
    // the last step lands together with the stop, so start + 2 * inc is shown
    chk("simmax", 32'h898, mx);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h30);
    w(3);
    chk("run", 32'h1, sim_active);
    wr(8'h00, 32'h38);
    w(3);
    chk("stop", 32'h0, sim_active);
    chk("meas", 32'h0, flow_out);
    // static flow simulation holds the start value
    wr(8'h00, 32'h50);
    w(40);
    chk("static", 32'h7D0, flow_out);
    test_done();
  end
endmodule
